// File: logic/i2b_core.sv
// Bit-level two-wire interface with AHB-Lite register access
//
// Summary of operation
// [R1] Clearing data-ready alone does not release SCL while other flags remain
// [R2] Arbitration loss needs transmit-active and clears transmit-active
// [R3] Lost when sent one or repeated start but SDA low at SCL rise
// [R4] Lost when sent one and another device made a start
// [R5] Master repeated start lost when SCL falls before SDA pulled low
// [R6] Master stop lost when SDA stays low after release
// [R7] Start-seen set for master or non-idle slave only
// [R8] Stop-seen set for master or non-idle slave only
// [R9] Master status set when master request is one and bus free
// [R10] Master status cleared by arbitration loss or completed stop
// [R11] Transmit-active set by data write, repeated-start or stop command
// [R12] Transmit-active cleared by data read or clear command
// [R13] Arbitration flagged only while transmit-active; SDA pulled low only while transmit-active or in a generated start
// [R14] Idle command ignores bus until next start; stop may grant mastership
// [R15] Data-ready cleared by command or data register access
// [R16] Clear commands clear flags; SCL held low while any flag set for master or non-idle slave, or while arbitration-lost set
// [R17] Repeated start releases SDA while low, pulls low after min high
// [R18] Initial start is automatic; software commands only while master
// [R19] Stop drives SDA low while low, releases after min high
// [R20] Software clears master request before sending the final stop
// [R21] Software checks data-ready first, then the other flags
// [R22] Attention reads one whenever any of the four flags is one
// [R23] Data-ready set at SCL rise for master or non-idle slave; receive bit captured at every SCL rise
// [R24] Transmit bit reaches SDA only while SCL is low
// [R25] Timing select sets min SCL high/low and start/stop timing
// [R26] Commands in one write act together; clear commands are pulses
`timescale 1ns/1ps
`include "i2b_consts.svh"
module i2b_core (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire i2b_pkg::i2b_word_t haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire i2b_pkg::i2b_word_t hwdata,
    input  wire logic              hready,
    output i2b_pkg::i2b_word_t     hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe
);
    import i2b_pkg::*;

    i2b_pin_if pin ();

    i2b_pin_sync u_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .ce     (ce),
        .scl_i  (scl_i),
        .sda_i  (sda_i),
        .pin    (pin)
    );

    function automatic logic [7:0] min_cnt(input logic [1:0] ct);
        unique case (ct)
            2'h0:    min_cnt = `I2B_MIN_CT0;
            2'h1:    min_cnt = `I2B_MIN_CT1;
            2'h2:    min_cnt = `I2B_MIN_CT2;
            default: min_cnt = `I2B_MIN_CT3;
        endcase
    endfunction : min_cnt

    function automatic logic idx_is(input logic [7:0] idx,
                                    input logic [7:0] ref_idx);
        idx_is = (idx == ref_idx);
    endfunction : idx_is

    i2b_byte_t  cfg_r;
    i2b_word_t  hrdata_r;
    logic       wr_pend_r;
    logic [7:0] wr_idx_r;
    logic       xa_r;
    logic       xbit_r;
    logic       receive_bit_r;
    logic       data_ready_flag_r;
    logic       arl_r;
    logic       str_r;
    logic       stp_r;
    logic       master_r;
    logic       idle_r;
    logic       busy_r;
    logic       pend_rs_r;
    logic       pend_sp_r;
    logic       init_r;
    logic       stretch_r;
    logic       scl_oe_r;
    logic       sda_oe_r;
    logic       hrdy_r;
    logic [7:0] cnt_r;
    i2b_mst_e   mst_r;
    i2b_mst_e   mst_nxt;

    // Bus slave: zero wait states, writes land at the end of the data phase
    logic       take;
    logic       addr_ok;
    logic [7:0] idx;
    logic       rd_dat;
    logic [7:0] wb;
    logic       wr_cfg;
    logic       wr_ctl;
    logic       wr_dat;

    assign take    = hsel & htrans[1] & hready & ce;
    assign addr_ok = (haddr[31:`I2B_ADDR_TOP] == '0) &&
                     (haddr[`I2B_IDX_LSB-1:0] == '0);
    assign idx     = haddr[`I2B_IDX_MSB:`I2B_IDX_LSB];
    assign rd_dat  = take & ~hwrite & addr_ok & idx_is(idx, `I2B_IDX_DAT);
    assign wb      = hwdata[7:0];
    assign wr_cfg  = ce & wr_pend_r & idx_is(wr_idx_r, `I2B_IDX_CFG);
    assign wr_ctl  = ce & wr_pend_r & idx_is(wr_idx_r, `I2B_IDX_CTL);
    assign wr_dat  = ce & wr_pend_r & idx_is(wr_idx_r, `I2B_IDX_DAT);

    // One-shot commands, never stored
    logic c_cxa, c_idle, c_cdr, c_clear_arb_lost_cmd, c_clear_start_flag_cmd, c_clear_stop_flag_cmd, c_send_repeated_start_cmd, c_send_stop_cmd;
    assign c_cxa  = wr_ctl & wb[`I2B_B_CXA];  // R26
    assign c_idle = wr_ctl & wb[`I2B_B_IDLE];
    assign c_cdr  = wr_ctl & wb[`I2B_B_CDR];
    assign c_clear_arb_lost_cmd = wr_ctl & wb[`I2B_B_CLEAR_ARB_LOST_CMD];
    assign c_clear_start_flag_cmd = wr_ctl & wb[`I2B_B_CLEAR_START_FLAG_CMD];
    assign c_clear_stop_flag_cmd = wr_ctl & wb[`I2B_B_CLEAR_STOP_FLAG_CMD];
    assign c_send_repeated_start_cmd = wr_ctl & wb[`I2B_B_SEND_REPEATED_START_CMD];
    assign c_send_stop_cmd = wr_ctl & wb[`I2B_B_SEND_STOP_CMD];

    logic flags_any;
    logic act;
    logic own_start;
    logic cnt_done;
    logic gen;
    assign flags_any = data_ready_flag_r | arl_r | str_r | stp_r;
    assign act       = master_r | (cfg_r[`I2B_B_SLVEN] & ~idle_r);
    assign own_start = (mst_r == M_START);
    assign cnt_done  = cnt_r >= min_cnt(cfg_r[`I2B_B_CT_HI:`I2B_B_CT_LO]);
    assign gen       = (mst_r == M_START) | (mst_r == M_STOPD);

    // Arbitration loss, only ever while transmit-active
    logic arl_c1, arl_c2, arl_c3, arl_c4, arl_set;
    assign arl_c1  = pin.scl_rise & ~pin.sda & (xbit_r | pend_rs_r); // R3
    assign arl_c2  = pin.start_det & xbit_r & ~own_start;            // R4
    assign arl_c3  = master_r & pend_rs_r & (mst_r == M_HIGH) &
                     pin.scl_fall;                                  // R5
    assign arl_c4  = (mst_r == M_STOPD) & cnt_done & ~pin.sda;      // R6
    assign arl_set = xa_r & (arl_c1 | arl_c2 | arl_c3 | arl_c4);    // R13

    logic go_master;
    assign go_master = (mst_r == M_OFF) & ~master_r &
                       cfg_r[`I2B_B_MRQ] & ~busy_r;                 // R9

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= `I2B_BYTE_RST;
        end else if (ce && hready) begin
            wr_pend_r <= hsel & htrans[1] & hwrite & addr_ok;
            wr_idx_r  <= idx;
        end
    end

    // Read data is prepared at the address phase edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_r <= '0;
        end else if (take) begin
            hrdata_r <= '0;
            if (!hwrite && addr_ok) begin
                if (idx_is(idx, `I2B_IDX_CFG)) begin
                    hrdata_r[7:0] <= cfg_r;
                end else if (idx_is(idx, `I2B_IDX_CTL)) begin
                    hrdata_r[`I2B_B_RECEIVE_BIT] <= receive_bit_r;
                    hrdata_r[`I2B_B_ATN]  <= flags_any;     // R22
                    hrdata_r[`I2B_B_DATA_READY_FLAG] <= data_ready_flag_r;
                    hrdata_r[`I2B_B_ARL]  <= arl_r;
                    hrdata_r[`I2B_B_STR]  <= str_r;
                    hrdata_r[`I2B_B_STP]  <= stp_r;
                    hrdata_r[`I2B_B_MST]  <= master_r;
                end else if (idx_is(idx, `I2B_IDX_DAT)) begin
                    hrdata_r[`I2B_B_RECEIVE_BIT] <= receive_bit_r;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= `I2B_CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= wb & `I2B_CFG_WMASK;
        end
    end

    // Transmit-active and the bit to transmit
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            xa_r   <= 1'b0;
            xbit_r <= 1'b1;
        end else if (ce) begin
            if (arl_set) begin
                xa_r <= 1'b0;                                       // R2
            end else if (wr_dat | c_send_repeated_start_cmd | c_send_stop_cmd) begin
                xa_r <= 1'b1;                                       // R11
            end else if (rd_dat | c_cxa) begin
                xa_r <= 1'b0;                                       // R12
            end
            if (wr_dat) begin
                xbit_r <= wb[`I2B_B_TRANSMIT_BIT];
            end else if (c_send_repeated_start_cmd) begin
                xbit_r <= 1'b1;                                     // R17
            end else if (c_send_stop_cmd) begin
                xbit_r <= 1'b0;                                     // R19
            end
        end
    end

    // Status flags: a hardware set wins over a software clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_ready_flag_r <= 1'b0;
            arl_r  <= 1'b0;
            str_r  <= 1'b0;
            stp_r  <= 1'b0;
            receive_bit_r <= 1'b0;
        end else if (ce) begin
            if ((act & pin.scl_rise) |
                (init_r & (mst_r == M_START) & cnt_done)) begin
                data_ready_flag_r <= 1'b1;                                     // R23
            end else if (c_cdr | rd_dat | wr_dat) begin
                data_ready_flag_r <= 1'b0;                                     // R15
            end
            if (pin.scl_rise) begin
                receive_bit_r <= pin.sda;                                  // R23
            end
            if (arl_set) begin
                arl_r <= 1'b1;
            end else if (c_clear_arb_lost_cmd) begin
                arl_r <= 1'b0;                                      // R16
            end
            if (pin.start_det & ~own_start & act) begin
                str_r <= 1'b1;                                      // R7
            end else if (c_clear_start_flag_cmd) begin
                str_r <= 1'b0;                                      // R16
            end
            if (pin.stop_det & act) begin
                stp_r <= 1'b1;                                      // R8
            end else if (c_clear_stop_flag_cmd) begin
                stp_r <= 1'b0;                                      // R16
            end
        end
    end

    // Bus ownership and slave idling
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r   <= 1'b0;
            idle_r   <= 1'b0;
            master_r <= 1'b0;
            init_r   <= 1'b0;
        end else if (ce) begin
            if (pin.start_det) begin
                busy_r <= 1'b1;
            end else if (pin.stop_det) begin
                busy_r <= 1'b0;                                     // R14
            end
            if (pin.start_det) begin
                idle_r <= 1'b0;
            end else if (c_idle) begin
                idle_r <= 1'b1;                                     // R14
            end
            if (arl_set | ((mst_r == M_STOPD) & cnt_done)) begin
                master_r <= 1'b0;                                   // R10
            end else if (go_master) begin
                master_r <= 1'b1;                                   // R9
            end
            if (go_master) begin
                init_r <= 1'b1;                                     // R18
            end else if (mst_r != M_START) begin
                init_r <= 1'b0;
            end
        end
    end

    // Repeated start and stop wait for the next SCL high phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_rs_r <= 1'b0;
            pend_sp_r <= 1'b0;
        end else if (ce) begin
            if (arl_set | (mst_nxt == M_START)) begin
                pend_rs_r <= 1'b0;
            end else if (c_send_repeated_start_cmd & master_r) begin
                pend_rs_r <= 1'b1;                                  // R18
            end
            if (arl_set | (mst_nxt == M_STOPD)) begin
                pend_sp_r <= 1'b0;
            end else if (c_send_stop_cmd & master_r) begin
                pend_sp_r <= 1'b1;                                  // R18
            end
        end
    end

    // Master clock generator
    always_comb begin
        mst_nxt = mst_r;
        unique case (mst_r)
            M_OFF: begin
                if (go_master) begin
                    mst_nxt = M_START;
                end
            end
            M_START: begin
                if (!master_r) begin
                    mst_nxt = M_OFF;
                end else if (cnt_done) begin
                    mst_nxt = M_LOW;                                // R25
                end
            end
            M_LOW: begin
                if (!master_r) begin
                    mst_nxt = M_OFF;
                end else if (cnt_done && !flags_any) begin
                    mst_nxt = M_HIGH;                               // R1
                end
            end
            M_HIGH: begin
                if (!master_r || arl_set) begin
                    mst_nxt = M_OFF;
                end else if (pin.scl && cnt_done) begin
                    if (pend_rs_r) begin
                        mst_nxt = M_START;                          // R17
                    end else if (pend_sp_r) begin
                        mst_nxt = M_STOPD;                          // R19
                    end else begin
                        mst_nxt = M_LOW;
                    end
                end
            end
            M_STOPD: begin
                if (cnt_done) begin
                    mst_nxt = M_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mst_r <= M_OFF;
        end else if (ce) begin
            mst_r <= mst_nxt;
        end
    end

    // Counts from each SCL edge or state change, so a stretched clock
    // from another party restarts the minimum time
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (pin.scl_rise | pin.scl_fall | (mst_nxt != mst_r)) begin
                cnt_r <= '0;                                        // R25
            end else if (cnt_r != `I2B_CNT_MAX) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    // Line drivers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stretch_r <= 1'b0;
            scl_oe_r  <= 1'b0;
            sda_oe_r  <= 1'b0;
            hrdy_r    <= 1'b0;
        end else if (ce) begin
            hrdy_r    <= 1'b1;
            stretch_r <= flags_any & (act | arl_r) &
                         (~pin.scl | stretch_r);                    // R16
            scl_oe_r  <= (mst_nxt == M_LOW) | (mst_nxt == M_START &&
                         mst_r == M_LOW) | stretch_r;
            if (mst_r == M_START) begin
                sda_oe_r <= 1'b1;                                   // R17
            end else if (mst_r == M_STOPD) begin
                sda_oe_r <= 1'b0;                                   // R19
            end else if (!xa_r) begin
                sda_oe_r <= 1'b0;                                   // R13
            end else if (!pin.scl) begin
                sda_oe_r <= ~xbit_r;                                // R24
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hrdy_r;
    assign hresp     = 1'b0;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = scl_oe_r;
    assign sda_oe    = sda_oe_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_xmit_write;
        ce && (wr_dat || c_send_repeated_start_cmd || c_send_stop_cmd) && !arl_set;
    endsequence
    sequence s_arb_event;
        ce && arl_set;
    endsequence

    a_xa_sets: assert property (s_xmit_write |=> xa_r) // R11
        else $error("transmit-active not set by write");
    a_xa_clears: assert property (ce && (rd_dat || c_cxa) && !wr_dat &&
        !c_send_repeated_start_cmd && !c_send_stop_cmd |=> !xa_r) // R12
        else $error("transmit-active not cleared");
    a_arl_effect: assert property (s_arb_event |=> arl_r && !xa_r
        && !master_r) // R2
        else $error("arbitration loss effects missing");
    a_arl_gate: assert property ($rose(arl_r) |-> $past(xa_r)) // R13
        else $error("arbitration loss without transmit-active");
    a_data_ready_flag_rise: assert property (ce && act && pin.scl_rise
        |=> data_ready_flag_r && receive_bit_r == $past(pin.sda)) // R23
        else $error("data-ready not set at SCL rise");
    a_attn_read: assert property (take && !hwrite && addr_ok &&
        idx_is(idx, `I2B_IDX_CTL)
        |=> hrdata_r[`I2B_B_ATN] == $past(flags_any)) // R22
        else $error("attention bit wrong");
    a_stretch_hold: assert property (ce && stretch_r && flags_any &&
        (act || arl_r) |=> scl_oe_r) // R16
        else $error("SCL released while a flag is set");
    a_tx_low_only: assert property (ce && xa_r && $past(xa_r) &&
        !$past(gen) && $changed(sda_oe_r) |-> !$past(pin.scl)) // R24
        else $error("SDA changed while SCL high");
    a_start_flag: assert property (ce && pin.start_det && !own_start &&
        act |=> str_r) // R7
        else $error("start-seen not set");
    a_master_set: assert property (ce && go_master && !arl_set
        |=> master_r ##0 mst_r == M_START) // R9
        else $error("mastership not taken on free bus");
endmodule : i2b_core

// File: logic/i2b_consts.svh
// Register indices, field positions, reset values and timing counts
`ifndef I2B_CONSTS_SVH
`define I2B_CONSTS_SVH

// Register indices; byte address is four times the index
`define I2B_IDX_CFG   8'hc8
`define I2B_IDX_CTL   8'hd8
`define I2B_IDX_DAT   8'hd9
`define I2B_IDX_LSB   2
`define I2B_IDX_MSB   9
`define I2B_ADDR_TOP  10

`define I2B_CFG_RST   8'h00
`define I2B_CFG_WMASK 8'hd3
`define I2B_BYTE_RST  8'h00

// Control register, read view
`define I2B_B_RECEIVE_BIT    7
`define I2B_B_ATN     6
`define I2B_B_DATA_READY_FLAG    5
`define I2B_B_ARL     4
`define I2B_B_STR     3
`define I2B_B_STP     2
`define I2B_B_MST     1
// Control register, write view
`define I2B_B_CXA     7
`define I2B_B_IDLE    6
`define I2B_B_CDR     5
`define I2B_B_CLEAR_ARB_LOST_CMD    4
`define I2B_B_CLEAR_START_FLAG_CMD    3
`define I2B_B_CLEAR_STOP_FLAG_CMD    2
`define I2B_B_SEND_REPEATED_START_CMD    1
`define I2B_B_SEND_STOP_CMD    0
// Data register
`define I2B_B_TRANSMIT_BIT    7
// Configuration register
`define I2B_B_SLVEN   7
`define I2B_B_MRQ     6
`define I2B_B_CT_HI   1
`define I2B_B_CT_LO   0

// Minimum SCL high/low time in mclk cycles per timing select code
`define I2B_MIN_CT0   8'h04
`define I2B_MIN_CT1   8'h08
`define I2B_MIN_CT2   8'h0c
`define I2B_MIN_CT3   8'h10
`define I2B_CNT_MAX   8'hff

`endif

// File: logic/i2b_pkg.sv
// Types shared by the bit-level two-wire interface
package i2b_pkg;
    typedef logic [31:0] i2b_word_t;
    typedef logic [7:0]  i2b_byte_t;
    typedef enum logic [2:0] {
        M_OFF,
        M_START,
        M_LOW,
        M_HIGH,
        M_STOPD
    } i2b_mst_e;
endpackage : i2b_pkg

// File: logic/i2b_pin_if.sv
// Synchronised bus levels and detected bus events
`timescale 1ns/1ps
interface i2b_pin_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : i2b_pin_if

// File: logic/i2b_pin_sync.sv
// Three-stage synchroniser and edge/start/stop detector for SCL and SDA
`timescale 1ns/1ps
module i2b_pin_sync (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic scl_i,
    input  wire logic sda_i,
    i2b_pin_if.src    pin
);
    logic [2:0] scl_f;
    logic [2:0] sda_f;
    logic       scl_s_r;
    logic       sda_s_r;
    logic       scl_nxt;
    logic       sda_nxt;
    logic       rise_r;
    logic       fall_r;
    logic       start_r;
    logic       stop_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_f <= 3'h7;
            sda_f <= 3'h7;
        end else if (ce) begin
            scl_f <= {scl_f[1:0], scl_i};
            sda_f <= {sda_f[1:0], sda_i};
        end
    end

    // A level counts only once stages two and three agree
    always_comb begin
        scl_nxt = (scl_f[1] == scl_f[2]) ? scl_f[2] : scl_s_r;
        sda_nxt = (sda_f[1] == sda_f[2]) ? sda_f[2] : sda_s_r;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_r <= 1'b1;
            sda_s_r <= 1'b1;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end else if (ce) begin
            scl_s_r <= scl_nxt;
            sda_s_r <= sda_nxt;
            rise_r  <= scl_nxt & ~scl_s_r;
            fall_r  <= ~scl_nxt & scl_s_r;
            start_r <= ~sda_nxt & sda_s_r & scl_nxt & scl_s_r;
            stop_r  <= sda_nxt & ~sda_s_r & scl_nxt & scl_s_r;
        end
    end

    assign pin.scl       = scl_s_r;
    assign pin.sda       = sda_s_r;
    assign pin.scl_rise  = rise_r;
    assign pin.scl_fall  = fall_r;
    assign pin.start_det = start_r;
    assign pin.stop_det  = stop_r;
endmodule : i2b_pin_sync

// File: sim/i2b_bus_model.sv
// Far-side bus party: another master pulling SCL/SDA low
`timescale 1ns/1ps
module i2b_bus_model (
    output logic scl_pd,
    output logic sda_pd
);
    initial begin
        scl_pd = 1'b0;
        sda_pd = 1'b0;
    end
    // From idle a plain start; from SCL low a repeated start
    task automatic start;
        #100 sda_pd = 1'b0;
        #100 scl_pd = 1'b0;
        #100 sda_pd = 1'b1;
        #100 scl_pd = 1'b1;
    endtask : start
    // SDA only moves while SCL is low, except for the stop itself
    task automatic stop;
        #100 sda_pd = 1'b1;
        #100 scl_pd = 1'b0;
        #100 sda_pd = 1'b0;
    endtask : stop
endmodule : i2b_bus_model

// File: sim/i2c_bit_level_status_control_tb_top.sv
// Self-checking bench for the bit-level two-wire interface
`timescale 1ns/1ps
`include "i2b_consts.svh"
module i2c_bit_level_status_control_tb_top;
    import i2b_pkg::*;
    logic       mclk, arst_n, hsel, hwrite, hrdy, hresp;
    logic [1:0] htrans;
    i2b_word_t  haddr, hwdata, hrdata;
    logic       scl_oe, sda_oe, scl_o, sda_o, scl_pd, sda_pd;
    logic [7:0] rd;
    int         fail_count = 0;
    int         cmp_count = 0;
    // Pull-ups: a line is low while any party pulls it
    wire scl_w = !(scl_oe || scl_pd);
    wire sda_w = !(sda_oe || sda_pd);
    i2b_core uut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    i2b_bus_model m (.scl_pd(scl_pd), .sda_pd(sda_pd));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge mclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hrdy !== 1'b1);
        rd = hrdata[7:0];
    endtask : bus
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic t_regs;
        bus(1'b0, `I2B_IDX_CFG, 8'h00);
        chk(rd, `I2B_CFG_RST);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h00);
        bus(1'b0, 8'h00, 8'h00);
        chk(rd, 8'h00);
        // Master request kept off so the block stays a slave
        bus(1'b1, `I2B_IDX_CFG, 8'hbf);
        bus(1'b0, `I2B_IDX_CFG, 8'h00);
        chk(rd, 8'hbf & `I2B_CFG_WMASK);
        $display("test regs done");
    endtask : t_regs
    task automatic t_flags;
        m.start;
        wt(12);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h48);
        chk({7'h0, scl_oe}, 8'h01);
        bus(1'b1, `I2B_IDX_CTL, 8'h08);
        wt(4);
        chk({7'h0, scl_oe}, 8'h00);
        m.start;
        wt(12);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'hfe, 8'he8);
        bus(1'b1, `I2B_IDX_CTL, 8'h20);
        wt(4);
        chk({7'h0, scl_oe}, 8'h01);
        bus(1'b1, `I2B_IDX_CTL, 8'h08);
        wt(4);
        chk({7'h0, scl_oe}, 8'h00);
        $display("test flags done");
    endtask : t_flags
    task automatic t_tx;
        bus(1'b1, `I2B_IDX_DAT, 8'h00);
        wt(6);
        chk({7'h0, sda_oe}, 8'h01);
        bus(1'b0, `I2B_IDX_DAT, 8'h00);
        wt(6);
        chk({7'h0, sda_oe}, 8'h00);
        $display("test transmit done");
    endtask : t_tx
    task automatic t_idle;
        bus(1'b1, `I2B_IDX_CTL, 8'h40);
        m.stop;
        wt(12);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h00);
        m.start;
        wt(12);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h00);
        m.stop;
        wt(12);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h64);
        $display("test idle done");
    endtask : t_idle
    task automatic t_mst;
        bus(1'b1, `I2B_IDX_CTL, 8'h24);
        bus(1'b1, `I2B_IDX_CFG, 8'hc3);
        wt(40);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h62);
        chk({7'h0, scl_oe}, 8'h01);
        bus(1'b1, `I2B_IDX_CFG, 8'h83);
        bus(1'b1, `I2B_IDX_CTL, 8'h21);
        wt(80);
        bus(1'b0, `I2B_IDX_CTL, 8'h00);
        chk(rd & 8'h7e, 8'h64);
        chk({7'h0, sda_oe}, 8'h00);
        $display("test master done");
    endtask : t_mst
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs;
        t_flags;
        t_tx;
        t_idle;
        t_mst;
        results;
    end
    initial begin
        #500000;
        fail_count++;
        results;
    end
endmodule : i2c_bit_level_status_control_tb_top
